/* File: sorb_regs.svh */
// Register offsets, field positions and reset values of the sample output register bank.
// Included by the design files and the bench; definitions only.
`ifndef SORB_REGS_SVH
`define SORB_REGS_SVH

`define SORB_OFF_Y_SHORT 8'h09
`define SORB_OFF_Z_SHORT 8'h0A
`define SORB_OFF_Y_HIGH 8'h10
`define SORB_OFF_Y_LOW 8'h11
`define SORB_OFF_Z_HIGH 8'h12
`define SORB_OFF_Z_LOW 8'h13
`define SORB_OFF_T_HIGH 8'h14
`define SORB_OFF_T_LOW 8'h15
`define SORB_OFF_A_HIGH 8'h16
`define SORB_OFF_A_LOW 8'h17
`define SORB_OFF_STATUS 8'h0B
`define SORB_DATA_FIRST 8'h08
`define SORB_DATA_LAST 8'h17
`define SORB_HIGH_MSB 13
`define SORB_HIGH_LSB 6
`define SORB_LOW_POS 2
`define SORB_RESET_BYTE 8'h00
`define SORB_RESP_OKAY 2'h0
`define SORB_RESP_SLVERR 2'h2

`endif

/* File: sorb_pkg.sv */
// Types shared by the sample output register bank.
// Assumes the offset header sorb_regs.svh is on the include path.
package sorb_pkg;
  typedef logic [13:0] sorb_sample_type;
  typedef logic [7:0] sorb_byte_type;
  typedef enum logic [1:0] {SORB_PAIR_IDLE, SORB_PAIR_Y, SORB_PAIR_Z} sorb_pair_type;
endpackage

/* File: sorb_sample_latch.sv */
// Snapshot of one sample set, taken in one cycle so high and low bytes always pair.
// Assumes sample inputs are synchronous to aclk and valid while take pulses.
`timescale 1ns/1ps
`include "sorb_regs.svh"
module sorb_sample_latch
  import sorb_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Sample source
  input wire logic take,
  input wire sorb_pkg::sorb_sample_type y_in,
  input wire sorb_pkg::sorb_sample_type z_in,
  input wire sorb_pkg::sorb_sample_type t_in,
  input wire sorb_pkg::sorb_sample_type a_in,
  // Held values
  output sorb_pkg::sorb_sample_type y_accel_value,
  output sorb_pkg::sorb_sample_type z_accel_value,
  output sorb_pkg::sorb_sample_type temp_value,
  output sorb_pkg::sorb_sample_type aux_input_value
);
  sorb_sample_type y_reg, z_reg, t_reg, a_reg;
  sorb_sample_type y_next, z_next, t_next, a_next;

  always_comb
  begin
    y_next = y_reg;
    z_next = z_reg;
    t_next = t_reg;
    a_next = a_reg;
    if (take)
    begin
      y_next = y_in;
      z_next = z_in;
      t_next = t_in;
      a_next = a_in;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      y_reg <= '0;
      z_reg <= '0;
      t_reg <= '0;
      a_reg <= '0;
    end
    else
    begin
      y_reg <= y_next;
      z_reg <= z_next;
      t_reg <= t_next;
      a_reg <= a_next;
    end
  end

  assign y_accel_value = y_reg;
  assign z_accel_value = z_reg;
  assign temp_value = t_reg;
  assign aux_input_value = a_reg;
endmodule // sorb_sample_latch

/* File: sorb_top.sv */
// Sample output register bank: read-only sample registers behind an AXI4-Lite slave.
// Assumes samples arrive on aclk with a one-cycle strobe; byte-sized registers per word.
//
// Operation
// - Y sample is 14-bit; bits 13:6 in Y high, bits 5:0 in Y low 7:2.
// - Reading Y low right after Y high clears the new-sample flag.
// - An 8-bit Y sample is readable at offset 0x09.
// - Z sample is 14-bit; bits 13:6 at 0x12, bits 5:0 in Z low 7:2.
// - Reading Z low at 0x13 right after Z high clears the flag.
// - An 8-bit Z sample is readable at offset 0x0A.
// - Temperature 14-bit; bits 13:6 at 0x14, bits 5:0 at 0x15 bits 7:2.
// - Aux input 14-bit; bits 13:6 at 0x16, bits 5:0 at 0x17 bits 7:2.
// - Low-byte bits 1:0 read zero; all sample bits reset to zero.
// - New sample during a data read sets the flag only after that read.
// - Flag sets on a new valid sample and clears on a Y or Z low read right after its high read.
`timescale 1ns/1ps
`include "sorb_regs.svh"
module sorb_top
  import sorb_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Sample source
  input wire logic sample_strobe,
  input wire sorb_pkg::sorb_sample_type y_sample,
  input wire sorb_pkg::sorb_sample_type z_sample,
  input wire sorb_pkg::sorb_sample_type temp_sample,
  input wire sorb_pkg::sorb_sample_type aux_sample,
  // Status
  output logic data_ready,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import sorb_pkg::*;

  function automatic sorb_byte_type high_byte(input sorb_sample_type v);
    high_byte = v[`SORB_HIGH_MSB:`SORB_HIGH_LSB];
  endfunction

  function automatic sorb_byte_type low_byte(input sorb_sample_type v);
    low_byte = {v[`SORB_HIGH_LSB-1:0], 2'h0};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Sample snapshot. A new sample is held back while a read is under way.

  sorb_sample_type y_val, z_val, t_val, a_val;
  logic pend_reg, pend_next;
  logic rd_busy;
  logic take;
  logic dr_reg, dr_next;

  // A pending sample is taken once the read ends, so no read sees a torn pair.
  assign take = (sample_strobe | pend_reg) & ~rd_busy;

  sorb_sample_latch u_latch (
    .aclk(aclk),
    .aresetn(aresetn),
    .take(take),
    .y_in(y_sample),
    .z_in(z_sample),
    .t_in(temp_sample),
    .a_in(aux_sample),
    .y_accel_value(y_val),
    .z_accel_value(z_val),
    .temp_value(t_val),
    .aux_input_value(a_val)
  );

  // The pending copy is not separately stored: inputs are assumed to hold
  // until the next strobe, which keeps the snapshot to one register set.
  always_comb
  begin
    pend_next = pend_reg;
    if (take)
      pend_next = 1'b0;
    else if (sample_strobe)
      pend_next = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read channel.

  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [7:0] roff_reg, roff_next;
  logic rd_done;
  sorb_byte_type rd_byte;
  logic rd_hit;

  assign rd_busy = s_axi_arvalid | rvalid_reg;
  assign rd_done = rvalid_reg & s_axi_rready;

  always_comb
  begin
    rd_byte = `SORB_RESET_BYTE;
    rd_hit = 1'b1;
    case ({2'h0, s_axi_araddr[7:2]})
      `SORB_OFF_Y_SHORT: rd_byte = high_byte(y_val);
      `SORB_OFF_Z_SHORT: rd_byte = high_byte(z_val);
      `SORB_OFF_STATUS: rd_byte = {7'h00, dr_reg};
      `SORB_OFF_Y_HIGH: rd_byte = high_byte(y_val);
      `SORB_OFF_Y_LOW: rd_byte = low_byte(y_val);
      `SORB_OFF_Z_HIGH: rd_byte = high_byte(z_val);
      `SORB_OFF_Z_LOW: rd_byte = low_byte(z_val);
      `SORB_OFF_T_HIGH: rd_byte = high_byte(t_val);
      `SORB_OFF_T_LOW: rd_byte = low_byte(t_val);
      `SORB_OFF_A_HIGH: rd_byte = high_byte(a_val);
      `SORB_OFF_A_LOW: rd_byte = low_byte(a_val);
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb
  begin
    arready_next = 1'b0;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    roff_next = roff_reg;
    if (rd_done)
      rvalid_next = 1'b0;
    if (s_axi_arvalid && !rvalid_reg && !arready_reg)
      arready_next = 1'b1;
    if (s_axi_arvalid && arready_reg)
    begin
      rvalid_next = 1'b1;
      rdata_next = {24'h000000, rd_byte};
      rresp_next = rd_hit ? `SORB_RESP_OKAY : `SORB_RESP_SLVERR;
      roff_next = {2'h0, s_axi_araddr[7:2]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data-ready flag and ordered-pair tracking.

  sorb_pair_type pair_reg, pair_next;

  always_comb
  begin
    dr_next = dr_reg;
    pair_next = pair_reg;
    if (rd_done)
    begin
      case (roff_reg)
        `SORB_OFF_Y_HIGH: pair_next = SORB_PAIR_Y;
        `SORB_OFF_Z_HIGH: pair_next = SORB_PAIR_Z;
        default: pair_next = SORB_PAIR_IDLE;
      endcase
      if (roff_reg == `SORB_OFF_Y_LOW && pair_reg == SORB_PAIR_Y)
        dr_next = 1'b0;
      if (roff_reg == `SORB_OFF_Z_LOW && pair_reg == SORB_PAIR_Z)
        dr_next = 1'b0;
    end
    // The set wins over a clear in the same cycle.
    if (take && (sample_strobe || pend_reg))
      dr_next = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write channel. Every register is read-only; writes are answered and dropped.

  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic aw_have_reg, aw_have_next;
  logic w_have_reg, w_have_next;

  always_comb
  begin
    awready_next = 1'b0;
    wready_next = 1'b0;
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (s_axi_awvalid && !aw_have_reg && !awready_reg && !bvalid_reg)
      awready_next = 1'b1;
    if (s_axi_wvalid && !w_have_reg && !wready_reg && !bvalid_reg)
      wready_next = 1'b1;
    if (s_axi_awvalid && awready_reg)
      aw_have_next = 1'b1;
    if (s_axi_wvalid && wready_reg)
      w_have_next = 1'b1;
    if (aw_have_reg && w_have_reg && !bvalid_reg)
    begin
      bvalid_next = 1'b1;
      // Nothing is stored: sample values and the flag stay untouched.
      bresp_next = `SORB_RESP_SLVERR;
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
    end
    if (bvalid_reg && s_axi_bready)
      bvalid_next = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pend_reg <= 1'b0;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `SORB_RESP_OKAY;
      roff_reg <= 8'h00;
      dr_reg <= 1'b0;
      pair_reg <= SORB_PAIR_IDLE;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `SORB_RESP_OKAY;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
    end
    else
    begin
      pend_reg <= pend_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      roff_reg <= roff_next;
      dr_reg <= dr_next;
      pair_reg <= pair_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
    end
  end

  assign data_ready = dr_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_low_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && arready_reg && s_axi_araddr[7:2] == `SORB_OFF_Y_LOW)
      |=> s_axi_rdata[1:0] == 2'h0 && s_axi_rdata[31:8] == 24'h000000)
    else $error("Low byte reserved bits not zero.");

  a_y_high_value: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && arready_reg && s_axi_araddr[7:2] == `SORB_OFF_Y_HIGH)
      |=> s_axi_rdata[7:0] == $past(y_val[13:6]))
    else $error("Y high byte wrong.");

  a_z_short_value: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && arready_reg && s_axi_araddr[7:2] == `SORB_OFF_Z_SHORT)
      |=> s_axi_rdata[7:0] == $past(z_val[13:6]))
    else $error("Z short byte wrong.");

  a_no_set_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    (!dr_reg && rd_busy) |=> !dr_reg)
    else $error("Flag set during a read.");

  a_strobe_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    (sample_strobe && !rd_busy) |=> dr_reg)
    else $error("Flag not set by a new sample.");

  a_pair_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_done && roff_reg == `SORB_OFF_Y_LOW && pair_reg == SORB_PAIR_Y
      && !take) |=> !dr_reg)
    else $error("Y pair did not clear flag.");

  a_z_pair_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_done && roff_reg == `SORB_OFF_Z_LOW && pair_reg == SORB_PAIR_Z
      && !take) |=> !dr_reg)
    else $error("Z pair did not clear flag.");

  a_stable_in_read: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_busy |=> $stable(y_val) && $stable(z_val))
    else $error("Sample changed during a read.");

  a_write_no_effect: assert property (@(posedge aclk) disable iff (!aresetn)
    (bvalid_reg && !$past(bvalid_reg)) |-> s_axi_bresp == `SORB_RESP_SLVERR)
    else $error("Write accepted.");
endmodule // sorb_top

/* File: sorb_host_model.sv */
// Host controller model: an AXI4-Lite master offering one read task and one write task.
// Assumes one caller at a time; the bench that calls it owns the timeout.
`timescale 1ns/1ps
module sorb_host_model
(
  // Clock
  input wire logic aclk,
  // Write channels
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  output logic bready,
  // Read channels
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  output logic rready
);
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // A nonzero delay holds rready off, so the slave must keep its answer standing.
  // Released address and data lines show the inverse, never the stale value.
  task automatic rd(input logic [7:0] a, input int dly);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (dly == 0);
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    repeat (dly) @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_pend;
    logic w_pend;
    aw_pend = 1'b1;
    w_pend = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw_pend || w_pend)
    begin
      @(posedge aclk);
      if (aw_pend && awready)
      begin
        awvalid <= 1'b0;
        awaddr <= ~a;
        aw_pend = 1'b0;
      end
      if (w_pend && wready)
      begin
        wvalid <= 1'b0;
        wdata <= ~d;
        w_pend = 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
  endtask
endmodule // sorb_host_model

/* File: test_sample_output_registers.sv */
// Self-checking bench for the sample output register bank.
// Assumes the design files and sorb_host_model are compiled first.
`timescale 1ns/1ps
`include "sorb_regs.svh"
`define TB_CHECK(got, want) \
  begin \
    compares++; \
    if ((got) !== (want)) \
    begin \
      miscompares++; \
      $display("mismatch at %0t: got %0h expected %0h", $time, got, want); \
    end \
  end
module test_sample_output_registers;
  import sorb_pkg::*;
  logic aclk;
  logic aresetn;
  logic sample_strobe;
  logic data_ready;
  sorb_sample_type smp [4];
  sorb_sample_type exp_s [4];
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [33:0] expq [$];
  logic [33:0] mon_exp, mon_got;
  int compares = 0;
  int miscompares = 0;
  logic [7:0] ids [10] = '{8'h09, 8'h0A, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17};
  sorb_top i_dut (.aclk(aclk), .aresetn(aresetn), .sample_strobe(sample_strobe),
    .y_sample(smp[0]), .z_sample(smp[1]), .temp_sample(smp[2]), .aux_sample(smp[3]),
    .data_ready(data_ready), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  sorb_host_model i_host (.aclk(aclk), .awaddr(s_axi_awaddr), .awvalid(s_axi_awvalid),
    .awready(s_axi_awready), .wdata(s_axi_wdata), .wstrb(s_axi_wstrb), .wvalid(s_axi_wvalid),
    .wready(s_axi_wready), .bvalid(s_axi_bvalid), .bready(s_axi_bready),
    .araddr(s_axi_araddr), .arvalid(s_axi_arvalid), .arready(s_axi_arready),
    .rvalid(s_axi_rvalid), .rready(s_axi_rready));
  ////////////////////////////////////////////////////////////////////////////////
  // Expected register word, worked out from the last sample set the design should hold.
  function automatic logic [31:0] ev(input logic [7:0] i);
    sorb_sample_type s;
    s = exp_s[(i - `SORB_OFF_Y_HIGH) >> 1];
    if (i == `SORB_OFF_Y_SHORT || i == `SORB_OFF_Z_SHORT)
      ev = {24'h0, exp_s[i - `SORB_OFF_Y_SHORT][13:6]};
    else if (i >= `SORB_OFF_Y_HIGH && i <= `SORB_OFF_A_LOW)
      ev = i[0] ? {24'h0, s[5:0], 2'b00} : {24'h0, s[13:6]};
    else
      ev = 32'h0;
  endfunction
  task automatic rchk(input logic [7:0] i, input logic [1:0] resp);
    expq.push_back({resp, ev(i)});
    i_host.rd({i[5:0], 2'b00}, int'($urandom % 3));
  endtask
  // The first set holds the extreme codes, later sets are random.
  task automatic pulse(input int n);
    @(posedge aclk);
    foreach (smp[k])
      smp[k] <= (n == 0) ? (k[0] ? 14'h1FFF : 14'h2000) : 14'($urandom);
    sample_strobe <= 1'b1;
    @(posedge aclk);
    sample_strobe <= 1'b0;
  endtask
  task automatic settle(input logic want);
    repeat (3) @(posedge aclk);
    `TB_CHECK(data_ready, want)
  endtask
  task automatic results;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk)
  begin
    if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready))
    begin
      mon_exp = (expq.size() > 0) ? expq.pop_front() : 34'h3_FFFF_FFFF;
      mon_got = s_axi_rvalid ? {s_axi_rresp, s_axi_rdata} : {s_axi_bresp, 32'h0};
      `TB_CHECK(mon_got, mon_exp)
    end
  end
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    results();
  end
  initial
  begin
    aresetn = 1'b0;
    sample_strobe = 1'b0;
    foreach (smp[k])
      smp[k] = '0;
    exp_s = smp;
    void'($urandom(28));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (ids[k])
      rchk(ids[k], `SORB_RESP_OKAY);
    `TB_CHECK(data_ready, 1'b0)
    $display("test reset_values done");
    for (int n = 0; n < 3; n++)
    begin
      pulse(n);
      exp_s = smp;
      settle(1'b1);
      for (int i = 8'h14; i <= 8'h17; i++)
        rchk(8'(i), `SORB_RESP_OKAY);
      rchk(`SORB_OFF_Y_SHORT, `SORB_RESP_OKAY);
      rchk(`SORB_OFF_Z_SHORT, `SORB_RESP_OKAY);
      rchk(`SORB_OFF_Y_HIGH, `SORB_RESP_OKAY);
      rchk(`SORB_OFF_Z_LOW, `SORB_RESP_OKAY);
      settle(1'b1);
      rchk(`SORB_OFF_Y_HIGH, `SORB_RESP_OKAY);
      rchk(`SORB_OFF_Y_LOW, `SORB_RESP_OKAY);
      settle(1'b0);
      pulse(n + 1);
      exp_s = smp;
      settle(1'b1);
      rchk(`SORB_OFF_Z_HIGH, `SORB_RESP_OKAY);
      rchk(`SORB_OFF_Z_LOW, `SORB_RESP_OKAY);
      settle(1'b0);
    end
    $display("test sample_layout done");
    pulse(1);
    exp_s = smp;
    settle(1'b1);
    expq.push_back({`SORB_RESP_SLVERR, 32'h0});
    i_host.wr(8'({`SORB_OFF_Y_HIGH, 2'b00}), 32'hFFFF_FFFF);
    expq.push_back({`SORB_RESP_SLVERR, 32'h0});
    i_host.wr(8'({`SORB_OFF_Y_LOW, 2'b00}), 32'h0);
    settle(1'b1);
    expq.push_back({`SORB_RESP_OKAY, 32'h1});
    i_host.rd(8'(`SORB_OFF_STATUS << 2), 0);
    rchk(8'h20, `SORB_RESP_SLVERR);
    rchk(8'h3F, `SORB_RESP_SLVERR);
    rchk(`SORB_OFF_Y_HIGH, `SORB_RESP_OKAY);
    rchk(`SORB_OFF_Y_LOW, `SORB_RESP_OKAY);
    settle(1'b0);
    $display("test write_refused done");
    fork
      rchk(`SORB_OFF_T_HIGH, `SORB_RESP_OKAY);
      pulse(2);
    join
    `TB_CHECK(data_ready, 1'b0)
    exp_s = smp;
    settle(1'b1);
    rchk(`SORB_OFF_T_HIGH, `SORB_RESP_OKAY);
    rchk(`SORB_OFF_T_LOW, `SORB_RESP_OKAY);
    repeat (4) @(posedge aclk);
    `TB_CHECK(expq.size(), 0)
    $display("test sample_during_read done");
    results();
  end
endmodule // test_sample_output_registers
